// File: core/flsc_pkg.sv
package flsc_pkg;
    // timing base
    localparam int CLK_MHZ        = 20;
    localparam int NS_PER_US      = 1000;
    localparam int STROBE_NS      = 100;
    localparam int RECOVER_NS     = 50;
    localparam int WAKE_READ_NS   = 1000;
    localparam int WAKE_WRITE_NS  = 1000;
    localparam int STROBE_CYC     =
        (STROBE_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
    localparam int RECOVER_CYC    =
        (RECOVER_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
    localparam int WAKE_READ_CYC  =
        (WAKE_READ_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
    localparam int WAKE_WRITE_CYC =
        (WAKE_WRITE_NS * CLK_MHZ + NS_PER_US - 1) / NS_PER_US;
    localparam int WAKE_CYC       = (WAKE_READ_CYC > WAKE_WRITE_CYC) ?
                                    WAKE_READ_CYC : WAKE_WRITE_CYC;

    // device command codes
    localparam logic [7:0] CMD_LOCK_SETUP   = 8'h60;
    localparam logic [7:0] CMD_CLR_CONFIRM  = 8'hD0;
    localparam logic [7:0] CMD_READ_ARRAY   = 8'hFF;
    localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;

    // device status byte
    localparam int SR_READY_BIT = 7;
    localparam int SR_ELC_BIT   = 5;
    localparam int SR_WLS_BIT   = 4;
    localparam int SR_SUP_BIT   = 3;
    localparam int SR_PROT_BIT  = 1;

    // own register map
    localparam int         ADDR_W   = 8;
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_EVT  = 8'h08;
    localparam logic [7:0] REG_MASK = 8'h0C;

    localparam int CTL_CLRLOCK = 0;
    localparam int CTL_CLRSTAT = 1;
    localparam int CTL_PDOWN   = 2;
    localparam int CTL_WAKE    = 3;

    localparam int EV_DONE   = 0;
    localparam int EV_SUPPLY = 1;
    localparam int EV_PROT   = 2;
    localparam int EV_SEQ    = 3;
    localparam int EV_CLRERR = 4;
    localparam int EV_ABORT  = 5;
    localparam int EV_W      = 6;

    localparam logic [EV_W-1:0] EVT_RST  = 6'h00;
    localparam logic [EV_W-1:0] MASK_RST = 6'h00;
    localparam logic [7:0]      SR_RST   = 8'h00;

    typedef enum logic [2:0] {
        S_IDLE    = 3'b000,
        S_SETUP   = 3'b001,
        S_CONFIRM = 3'b010,
        S_POLL    = 3'b011,
        S_RDARR   = 3'b100,
        S_CLRSR   = 3'b101,
        S_DOWN    = 3'b110,
        S_WAKE    = 3'b111
    } flsc_state_t;

    typedef enum logic [1:0] {
        B_IDLE = 2'b00,
        B_ACT  = 2'b01,
        B_REC  = 2'b10
    } flsc_bstate_t;
endpackage

// File: core/flsc_bus_cycle.sv
module flsc_bus_cycle import flsc_pkg::*; #(
    parameter int ACT_CYCLES = STROBE_CYC,
    parameter int REC_CYCLES = RECOVER_CYC
) (
    input  wire logic       clk,
    input  wire logic       reset,
    input  wire logic       start,
    input  wire logic       isWrite,
    input  wire logic [7:0] wrData,
    input  wire logic [7:0] dqIn,
    output logic            ready,
    output logic            done,
    output logic [7:0]      rdData,
    output logic            ceN,
    output logic            weN,
    output logic            oeN,
    output logic [7:0]      dqOut,
    output logic            dqOe
);
    flsc_bstate_t state_ff, nxt_state;
    logic [3:0]   cnt_ff;
    logic         wr_ff;
    logic [7:0]   dqOut_ff;
    logic [7:0]   rdData_ff;
    wire logic    actLast = (state_ff == B_ACT) &&
                            (cnt_ff == 4'(ACT_CYCLES - 1));
    wire logic    recLast = (state_ff == B_REC) &&
                            (cnt_ff == 4'(REC_CYCLES - 1));
    wire logic    active  = (state_ff == B_ACT);

    // we only ever falls together with ce, never alone
    assign ceN    = ~active;
    assign weN    = ~(active & wr_ff);
    assign oeN    = ~(active & ~wr_ff);
    assign dqOe   = active & wr_ff;
    assign dqOut  = dqOut_ff;
    assign rdData = rdData_ff;
    assign ready  = (state_ff == B_IDLE);
    assign done   = recLast;

    always_comb begin
        nxt_state = state_ff;
        unique case (state_ff)
            B_IDLE: if (start) nxt_state = B_ACT;
            B_ACT:  if (actLast) nxt_state = B_REC;
            B_REC:  if (recLast) nxt_state = B_IDLE;
            default: nxt_state = B_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_ff <= B_IDLE;
            cnt_ff   <= 4'h0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff   <= (nxt_state != state_ff) ? 4'h0 : cnt_ff + 4'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            wr_ff     <= 1'b0;
            dqOut_ff  <= 8'h00;
            rdData_ff <= 8'h00;
        end else begin
            if (ready && start) begin
                wr_ff    <= isWrite;
                dqOut_ff <= wrData;
            end
            // sampled on the last strobe cycle, oe still low
            if (actLast && !wr_ff)
                rdData_ff <= dqIn;
        end
    end

    a_we_within_ce: assert property (@(posedge clk) disable iff (reset)
        !weN |-> !ceN && oeN && dqOe)
        else $error("write strobe without chip enable");
    a_strobe_width: assert property (@(posedge clk) disable iff (reset)
        $fell(ceN) |-> !ceN [*2] ##1 ceN && done)
        else $error("strobe width wrong");
endmodule

// File: core/flsc_host.sv
// How it works
// - clear locks: write 60H, then D0H, poll until ready, then FFH.
// - an operation aborted by reset must be reissued in full.
// - after any lock operation issue read-array before array access.
// - after raising reset pin wait the wake intervals before access.
module flsc_host import flsc_pkg::*; #(
    parameter int WAKE_CYCLES = WAKE_CYC
) (
    input  wire logic              clk,
    input  wire logic              reset,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [31:0]       pwdata,
    output logic [31:0]            prdata,
    output logic                   pready,
    output logic                   pslverr,
    output logic                   irq,
    output logic                   ceN,
    output logic                   weN,
    output logic                   oeN,
    output logic                   rpN,
    output logic [7:0]             dqOut,
    output logic                   dqOe,
    input  wire logic [7:0]        dqIn,
    input  wire logic              stsIn
);
    flsc_state_t     state_ff, nxt_state;
    logic            pending_ff;
    logic            rpN_ff;
    logic [15:0]     wake_ff;
    logic [7:0]      srCap_ff;
    logic [EV_W-1:0] evt_ff, nxt_evt, evSet;
    logic [EV_W-1:0] mask_ff;
    logic [31:0]     prdata_ff;
    logic            cycReady, cycDone;
    logic [7:0]      cycRd;

    function automatic logic [7:0] cmdFor(input flsc_state_t s);
        unique case (s)
            S_SETUP:   cmdFor = CMD_LOCK_SETUP;
            S_CONFIRM: cmdFor = CMD_CLR_CONFIRM;
            S_CLRSR:   cmdFor = CMD_CLEAR_STATUS;
            default:   cmdFor = CMD_READ_ARRAY;
        endcase
    endfunction

    // register bus decode
    wire logic hitCtrl = (paddr == REG_CTRL);
    wire logic hitStat = (paddr == REG_STAT);
    wire logic hitEvt  = (paddr == REG_EVT);
    wire logic hitMask = (paddr == REG_MASK);
    wire logic mapped  = hitCtrl | hitStat | hitEvt | hitMask;
    wire logic wrEn    = psel & penable & pwrite & mapped;
    wire logic rdSetup = psel & ~penable;
    wire logic ctrlWr  = wrEn & hitCtrl;

    // sequencing requests; start commands only taken when idle
    wire logic inOp       = (state_ff == S_SETUP) | (state_ff == S_CONFIRM) |
                            (state_ff == S_POLL) | (state_ff == S_RDARR) |
                            (state_ff == S_CLRSR);
    wire logic isIdle     = (state_ff == S_IDLE);
    wire logic reqDown    = ctrlWr & pwdata[CTL_PDOWN] &
                            (state_ff != S_DOWN);
    wire logic reqClrLock = ctrlWr & pwdata[CTL_CLRLOCK] & isIdle & ~reqDown;
    wire logic reqClrStat = ctrlWr & pwdata[CTL_CLRSTAT] & isIdle &
                            ~reqDown & ~pwdata[CTL_CLRLOCK];
    wire logic reqWake    = ctrlWr & pwdata[CTL_WAKE] & ~pwdata[CTL_PDOWN] &
                            (state_ff == S_DOWN);
    wire logic wakeDone   = (state_ff == S_WAKE) &&
                            (wake_ff == 16'(WAKE_CYCLES - 1));
    // no device cycle while reset pin is low or the wake wait runs
    wire logic cycStart   = inOp & cycReady & ~pending_ff & ~reqDown &
                            rpN_ff;
    // a strobe already on the pins finishes before the reset pin drops
    wire logic cycBusy    = pending_ff & ~cycDone;
    wire logic dropRp     = (reqDown | (state_ff == S_DOWN)) & ~cycBusy;
    wire logic cycWrite   = (state_ff != S_POLL);
    wire logic opDone     = cycDone & pending_ff;
    wire logic pollOk     = (state_ff == S_POLL) & opDone &
                            cycRd[SR_READY_BIT];
    wire logic [EV_W-1:0] evClr = (wrEn & hitEvt) ?
                                  pwdata[EV_W-1:0] : {EV_W{1'b0}};
    wire logic [31:0] statWord = {18'h0_0000, state_ff, stsIn, ~rpN_ff,
                                  ~isIdle, srCap_ff};
    wire logic [31:0] rdVal =
        hitStat ? statWord :
        hitEvt  ? {{(32 - EV_W){1'b0}}, evt_ff} :
        hitMask ? {{(32 - EV_W){1'b0}}, mask_ff} : 32'h0000_0000;

    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata  = prdata_ff;
    assign rpN     = rpN_ff;
    assign irq     = |(evt_ff & mask_ff);

    flsc_bus_cycle flsc_bus_cycle_i (
        .clk     (clk),
        .reset   (reset),
        .start   (cycStart),
        .isWrite (cycWrite),
        .wrData  (cmdFor(state_ff)),
        .dqIn    (dqIn),
        .ready   (cycReady),
        .done    (cycDone),
        .rdData  (cycRd),
        .ceN     (ceN),
        .weN     (weN),
        .oeN     (oeN),
        .dqOut   (dqOut),
        .dqOe    (dqOe)
    );

    always_comb begin
        nxt_state = state_ff;
        if (reqDown) begin
            nxt_state = S_DOWN;
        end else begin
            unique case (state_ff)
                S_IDLE: begin
                    if (reqClrLock)
                        nxt_state = S_SETUP;
                    else if (reqClrStat)
                        nxt_state = S_CLRSR;
                end
                S_SETUP:   if (opDone) nxt_state = S_CONFIRM;
                S_CONFIRM: if (opDone) nxt_state = S_POLL;
                S_POLL:    if (pollOk) nxt_state = S_RDARR;
                // the lock sequence restores array read before going idle; clear status goes idle without it
                S_RDARR:   if (opDone) nxt_state = S_IDLE;
                S_CLRSR:   if (opDone) nxt_state = S_IDLE;
                S_DOWN:    if (reqWake) nxt_state = S_WAKE;
                S_WAKE:    if (wakeDone) nxt_state = S_IDLE;
            endcase
        end
    end

    // status decode only once the machine reports ready
    always_comb begin
        evSet            = {EV_W{1'b0}};
        evSet[EV_DONE]   = opDone & ((state_ff == S_RDARR) |
                                     (state_ff == S_CLRSR));
        evSet[EV_SUPPLY] = pollOk & cycRd[SR_SUP_BIT];
        evSet[EV_PROT]   = pollOk & cycRd[SR_PROT_BIT];
        evSet[EV_SEQ]    = pollOk & cycRd[SR_WLS_BIT] & cycRd[SR_ELC_BIT];
        evSet[EV_CLRERR] = pollOk & ~cycRd[SR_WLS_BIT] & cycRd[SR_ELC_BIT];
        // software must rerun the whole sequence after this
        evSet[EV_ABORT]  = reqDown & inOp;
        nxt_evt          = (evt_ff & ~evClr) | evSet;
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_ff   <= S_WAKE;
            pending_ff <= 1'b0;
            wake_ff    <= 16'h0000;
        end else begin
            state_ff   <= nxt_state;
            pending_ff <= cycStart | (pending_ff & ~cycDone);
            wake_ff    <= (state_ff == S_WAKE) ? wake_ff + 16'h0001
                                               : 16'h0000;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            rpN_ff   <= 1'b1;
            srCap_ff <= SR_RST;
        end else begin
            if (reqWake)
                rpN_ff <= 1'b1;
            else if (dropRp)
                rpN_ff <= 1'b0;
            // mirror of the device: reset pin low wipes its status
            if (reqDown)
                srCap_ff <= SR_RST;
            else if (pollOk)
                srCap_ff <= cycRd;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            evt_ff    <= EVT_RST;
            mask_ff   <= MASK_RST;
            prdata_ff <= 32'h0000_0000;
        end else begin
            evt_ff <= nxt_evt;
            if (wrEn && hitMask)
                mask_ff <= pwdata[EV_W-1:0];
            if (rdSetup)
                prdata_ff <= rdVal;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    a_confirm_after_setup: assert property (
        $rose(state_ff == S_CONFIRM) |-> $past(state_ff) == S_SETUP)
        else $error("confirm not preceded by setup");
    a_poll_until_ready: assert property (
        (state_ff == S_POLL) && opDone && !cycRd[SR_READY_BIT] && !reqDown
        |=> state_ff == S_POLL)
        else $error("poll left before ready");
    a_ready_read_array: assert property (
        pollOk && !reqDown |=> state_ff == S_RDARR ##0 !isIdle)
        else $error("no read array after ready");
    a_abort_flagged: assert property (
        reqDown && inOp |=> evt_ff[EV_ABORT] ##[0:3] !rpN)
        else $error("abort not reported");
    a_quiet_in_down: assert property (
        !rpN |-> ceN && weN && !cycStart)
        else $error("device cycle with reset pin low");
    a_wake_wait: assert property (
        $rose(rpN) |-> !cycStart [*8])
        else $error("access before wake interval");
    a_sticky_event: assert property (
        evt_ff[EV_SEQ] && !(wrEn && hitEvt) |=> evt_ff[EV_SEQ])
        else $error("event bit lost");
    a_irq_follows: assert property (
        $rose(evt_ff[EV_DONE]) && mask_ff[EV_DONE] |-> irq)
        else $error("irq missing");

    c_clear_locks: cover property ($fell(state_ff == S_RDARR) ##1 isIdle);
    c_poll_repeat: cover property ((state_ff == S_POLL) && opDone && !pollOk);
    c_abort:       cover property (reqDown && inOp);
    c_seq_error:   cover property (evSet[EV_SEQ]);
endmodule

// File: testbench/flsc_flash_model.sv
module flsc_flash_model import flsc_pkg::*; #(
    parameter int WAKE_MIN = 8
) (
    input  wire logic       clk,
    input  wire logic       ceN,
    input  wire logic       weN,
    input  wire logic       oeN,
    input  wire logic       rpN,
    input  wire logic [7:0] dqHost,
    input  wire logic [7:0] busyLen,
    input  wire logic [2:0] fault,
    output logic [7:0]      dq,
    output logic            sts,
    output logic [7:0]      sr,
    output logic [31:0]     cmdHist,
    output logic            early
);
    timeunit 1ns;
    timeprecision 1ns;
    logic       wasWr;
    logic       setup;
    logic       rdStat;
    logic       busy;
    logic [7:0] cmd;
    logic [7:0] cnt;
    logic [7:0] dqLast;
    logic [7:0] errBits;
    int         wake;

    // fault 1 supply, 2 protect, 3 clear failure, 4 bad confirm, 5 set fail
    assign errBits = (fault == 3'd1) ? 8'h28 :
                     (fault == 3'd2) ? 8'h02 :
                     (fault == 3'd3) ? 8'h20 :
                     (fault == 3'd5) ? 8'h10 : 8'h00;
    // pull-up wins whenever the pin is released
    assign sts = busy ? 1'b0 : 1'b1;

    // idle bus shows a changing pattern, never the last value
    always_comb begin
        if (!ceN && !oeN && rpN)
            dq = rdStat ? {!busy, sr[6:0]} : 8'hA5;
        else
            dq = ~dqLast;
    end

    initial begin
        {wasWr, setup, rdStat, busy, early} = '0;
        {cmd, cnt, dqLast, sr} = '0;
        cmdHist = '0;
        wake = 0;
    end

    always @(posedge clk) begin
        dqLast <= dq;
        if (!rpN) begin
            sr <= 8'h00;
            setup <= 1'b0;
            rdStat <= 1'b0;
            wasWr <= 1'b0;
            busy <= 1'b0;
            wake <= 0;
        end else begin
            if (wake < WAKE_MIN)
                wake <= wake + 1;
            if (!ceN && (!weN || !oeN) && wake < WAKE_MIN)
                early <= 1'b1;
            wasWr <= !ceN && !weN;
            if (!ceN && !weN)
                cmd <= dqHost;
            if (busy) begin
                cnt <= cnt - 8'd1;
                if (cnt == 8'd1) begin
                    busy <= 1'b0;
                    sr <= sr | errBits;
                end
            end
            if (wasWr && weN) begin
                cmdHist <= {cmdHist[23:0], cmd};
                if (setup) begin
                    setup <= 1'b0;
                    if (cmd == CMD_CLR_CONFIRM && fault != 3'd4) begin
                        busy <= 1'b1;
                        cnt <= busyLen;
                    end else
                        sr[5:4] <= 2'b11;
                end else if (cmd == CMD_LOCK_SETUP) begin
                    setup <= 1'b1;
                    rdStat <= 1'b1;
                end else if (cmd == CMD_CLEAR_STATUS)
                    sr <= 8'h00;
                else if (cmd == CMD_READ_ARRAY)
                    rdStat <= 1'b0;
            end
        end
    end
endmodule

// File: testbench/flsc_host_test.sv
module flsc_host_test import flsc_pkg::*;;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk, reset, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0]  paddr, dqOut, dqIn, busyLen;
    logic [31:0] pwdata, prdata, cmdHist, r;
    logic        ceN, weN, oeN, rpN, dqOe, stsIn, early, lastErr;
    logic [7:0]  sr;
    logic [2:0]  fault;
    int          nFail, totalChecks, cycles;

    flsc_host #(.WAKE_CYCLES(9)) flsc_host_i (.clk(clk), .reset(reset),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .irq(irq), .ceN(ceN), .weN(weN), .oeN(oeN),
        .rpN(rpN), .dqOut(dqOut), .dqOe(dqOe), .dqIn(dqIn),
        .stsIn(stsIn));
    flsc_flash_model flsc_flash_model_i (.clk(clk), .ceN(ceN), .weN(weN),
        .oeN(oeN), .rpN(rpN), .dqHost(dqOut), .busyLen(busyLen),
        .fault(fault), .dq(dqIn), .sts(stsIn), .sr(sr),
        .cmdHist(cmdHist), .early(early));

    initial clk = 1'b0;
    always #25 clk = ~clk;

    task automatic endSim;
        $display("checks %0d mismatches %0d", totalChecks, nFail);
        if (nFail == 0 && totalChecks > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            nFail++;
            endSim;
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string msg);
        totalChecks++;
        if (got !== exp) begin
            $display("unexpected at %0t: %s got %h", $time, msg, got);
            nFail++;
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] q);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        q = prdata;
        lastErr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        apb(1'b1, a, d, q);
    endtask

    task automatic waitIdle;
        r = 32'h0000_0100;
        for (int i = 0; i < 300 && r[8] !== 1'b0; i++)
            apb(1'b0, REG_STAT, 32'h0000_0000, r);
    endtask

    task automatic runClear(input logic [2:0] f);
        fault <= f;
        wr(REG_EVT, 32'h0000_003F);
        wr(REG_CTRL, 32'h0000_0001);
        waitIdle;
    endtask

    task automatic testClearLocks;
        runClear(3'd0);
        chk(cmdHist[23:0], 32'h0060_D0FF, "command order");
        chk(r[7:0], 32'h0000_0080, "ready status");
        wr(REG_MASK, 32'h0000_0001);
        @(negedge clk);
        chk(irq, 1'b1, "irq on done");
        wr(REG_EVT, 32'h0000_0001);
        @(negedge clk);
        chk(irq, 1'b0, "irq after clear");
        wr(REG_MASK, 32'h0000_0000);
        apb(1'b0, 8'h10, 32'h0000_0000, r);
        chk(lastErr, 1'b1, "unmapped error");
        chk(r, 32'h0000_0000, "unmapped read");
    endtask

    task automatic testErrors;
        logic [2:0]  fl[5] = '{3'd1, 3'd2, 3'd3, 3'd4, 3'd5};
        logic [31:0] ev[5] = '{32'h12, 32'h04, 32'h10, 32'h08, 32'h00};
        logic [7:0]  st[5] = '{8'hA8, 8'h82, 8'hA0, 8'hB0, 8'h90};
        for (int i = 0; i < 5; i++) begin
            wr(REG_CTRL, 32'h0000_0002);
            waitIdle;
            runClear(fl[i]);
            chk(r[7:0], st[i], "status bits");
            apb(1'b0, REG_EVT, 32'h0000_0000, r);
            chk(r & 32'h3E, ev[i], "error events");
        end
    endtask

    task automatic testSticky;
        wr(REG_CTRL, 32'h0000_0002);
        waitIdle;
        runClear(3'd2);
        runClear(3'd3);
        chk(r[7:0], 8'hA2, "errors accumulate");
        wr(REG_CTRL, 32'h0000_0002);
        waitIdle;
        runClear(3'd0);
        chk(r[7:0], 8'h80, "clear status");
    endtask

    task automatic testPowerDown;
        busyLen <= 8'd60;
        wr(REG_EVT, 32'h0000_003F);
        wr(REG_CTRL, 32'h0000_0001);
        r = 32'h0000_0400;
        for (int i = 0; i < 50 && r[10] !== 1'b0; i++)
            apb(1'b0, REG_STAT, 32'h0000_0000, r);
        chk(r[10], 1'b0, "ready pin low while busy");
        wr(REG_CTRL, 32'h0000_0004);
        apb(1'b0, REG_EVT, 32'h0000_0000, r);
        chk(r[5], 1'b1, "abort event");
        apb(1'b0, REG_STAT, 32'h0000_0000, r);
        chk({r[9], r[7:0], sr}, 17'h1_0000, "status cleared");
        for (int i = 0; i < 20; i++) begin
            @(negedge clk);
            chk({rpN, ceN}, 2'b01, "no cycle when down");
        end
        wr(REG_CTRL, 32'h0000_0008);
        waitIdle;
        busyLen <= 8'd6;
        runClear(3'd0);
        apb(1'b0, REG_EVT, 32'h0000_0000, r);
        chk(r[0], 1'b1, "reissued operation");
        chk(cmdHist[23:0], 32'h0060_D0FF, "full sequence again");
        chk(early, 1'b0, "wake interval kept");
    endtask

    initial begin
        {reset, psel, penable, pwrite} = 4'b1000;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
        busyLen = 8'd6;
        fault = 3'd0;
        repeat (4) @(posedge clk);
        reset <= 1'b0;
        waitIdle;
        chk(r, 32'h0000_0400, "idle status");
        apb(1'b0, REG_MASK, 32'h0000_0000, r);
        chk(r, 32'h0000_0000, "mask reset");
        testClearLocks;
        testErrors;
        testSticky;
        testPowerDown;
        endSim;
    end
endmodule
